// ### src/breaker_failure_top.sv
// breaker-failure supervision: APB registers, state machine and lockout
// Notes on behaviour
// [RULE1] selected trigger starts supervision timer
// [RULE2] timer keeps running after trigger drops
// [RULE3] expiry before opening issues breaker-failure trip
// [RULE4] detected opening stops timer without trip
// [RULE5] current scheme: opened when current below threshold
// [RULE6] position scheme: opened when indicator shows open
// [RULE7] combined: fail only if current high, not open
// [RULE8] opening with trigger still active enters rejected
// [RULE9] rejected holds while trigger stays asserted
// [RULE10] all triggers low returns to stand-by
// [RULE11] lockout rises together with the trip
// [RULE12] lockout latched until operator acknowledge
// [RULE13] three extra triggers start regardless of source
// [RULE14] any-assigned source: every assigned trip starts
// [RULE15] external source: only external trips start
// [RULE16] overcurrent source: only current trips start
// [RULE17] no source: only extra triggers start
// [RULE18] configured supervision time exceeds total clearing time
// [RULE19] low current with breaker open: no pickup
// [RULE20] trigger is OR of selected trips, extras
// [RULE21] trip held until triggers drop, then stand-by
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/100ps
module breaker_failure_top #(
  parameter logic [31:0] DEF_SUP_TIME_CYC = 32'(bf_pkg::SUP_TIME_CYC)
) (
  input  wire logic                     core_clk_i,         // system clock, 125 MHz
  input  wire logic                     sys_rst_i,          // sync reset, active high
  input  wire logic                     psel,               // apb select
  input  wire logic                     penable,            // apb access phase
  input  wire logic                     pwrite,             // apb write
  input  wire logic [7:0]               paddr,              // apb byte address
  input  wire logic [31:0]              pwdata,             // apb write data
  output logic                          pready,             // apb ready
  output logic [31:0]                   prdata,             // apb read data
  output logic                          pslverr,            // apb error, unmapped
  input  wire logic                     trip_ext_i,         // external trip command
  input  wire logic                     trip_oc_i,          // overcurrent trip command
  input  wire logic                     trip_other_i,       // other assigned trip
  input  wire logic                     extra_trigger_a_i,  // extra trigger a (pin)
  input  wire logic                     extra_trigger_b_i,  // extra trigger b (pin)
  input  wire logic                     extra_trigger_c_i,  // extra trigger c (pin)
  input  wire logic                     pos_open_i,         // breaker open (pin)
  input  wire logic [bf_pkg::CUR_W-1:0] current_i,          // measured current
  output logic                          breaker_failure_o,  // backup trip
  output logic                          lockout_o           // latched close inhibit
);
  sup_if sif ();

  bf_pkg::state_t              state;
  bf_pkg::state_t              next_state;
  logic [1:0]                  scheme;
  logic [1:0]                  src_sel;
  logic [31:0]                 supervision_time;
  logic [bf_pkg::CUR_W-1:0]    failure_current_threshold;
  logic                        lockout;
  logic                        trip;
  logic [31:0]                 rd_data;

  logic                        setup_ph;
  logic                        access_ph;
  logic                        wr_en;
  logic                        hit_ctrl;
  logic                        hit_time;
  logic                        hit_thresh;
  logic                        hit_status;
  logic                        hit_ack;
  logic                        hit_remain;
  logic                        mapped;
  logic                        ack_wr;
  logic                        cur_low;
  logic                        opened;
  logic                        no_pickup;
  logic                        start;
  logic                        enter_trip;

  bf_trigger_sel u_trig (
    .core_clk_i        (core_clk_i),
    .sys_rst_i         (sys_rst_i),
    .trip_ext_i        (trip_ext_i),
    .trip_oc_i         (trip_oc_i),
    .trip_other_i      (trip_other_i),
    .extra_trigger_a_i (extra_trigger_a_i),
    .extra_trigger_b_i (extra_trigger_b_i),
    .extra_trigger_c_i (extra_trigger_c_i),
    .pos_open_i        (pos_open_i),
    .sif               (sif.sel)
  );

  bf_sup_timer u_tmr (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .sif        (sif.timer)
  );

  // one compare shared by every register select
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
    return (addr == offset);
  endfunction

  // ---- apb slave: zero wait states, read data captured in setup phase
  assign setup_ph   = psel && !penable;
  assign access_ph  = psel && penable;
  assign hit_ctrl   = reg_hit(paddr, bf_pkg::OFF_CTRL);
  assign hit_time   = reg_hit(paddr, bf_pkg::OFF_TIME);
  assign hit_thresh = reg_hit(paddr, bf_pkg::OFF_THRESH);
  assign hit_status = reg_hit(paddr, bf_pkg::OFF_STATUS);
  assign hit_ack    = reg_hit(paddr, bf_pkg::OFF_ACK);
  assign hit_remain = reg_hit(paddr, bf_pkg::OFF_REMAIN);
  assign mapped     = hit_ctrl | hit_time | hit_thresh | hit_status | hit_ack | hit_remain;
  assign wr_en      = access_ph && pwrite && mapped;
  assign pready     = access_ph;
  assign pslverr    = access_ph && !mapped;
  assign ack_wr     = wr_en && hit_ack && pwdata[bf_pkg::ACK_BIT];  // [RULE12]

  assign rd_data =
    hit_ctrl   ? {28'h0, src_sel, scheme} :
    hit_time   ? supervision_time :
    hit_thresh ? {16'h0, failure_current_threshold} :
    hit_status ? {26'h0, opened, sif.trig, lockout, trip, state} :
    hit_remain ? sif.remain :
    32'h0;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      prdata <= 32'h0;
    end else if (setup_ph && !pwrite) begin
      prdata <= rd_data;
    end
  end

  // RULE18 is the configurer's: a time shorter than clearing time gives false trips
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      scheme                    <= bf_pkg::RST_SCHEME;
      src_sel                   <= bf_pkg::RST_SRC;
      supervision_time          <= DEF_SUP_TIME_CYC;
      failure_current_threshold <= bf_pkg::RST_THRESH;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        scheme  <= pwdata[bf_pkg::CTRL_SCHEME_LSB +: 2];
        src_sel <= pwdata[bf_pkg::CTRL_SRC_LSB +: 2];
      end
      if (hit_time) begin
        supervision_time <= pwdata;  // [RULE18]
      end
      if (hit_thresh) begin
        failure_current_threshold <= pwdata[bf_pkg::CUR_W-1:0];
      end
    end
  end

  // ---- opening detection per scheme
  assign cur_low = (current_i < failure_current_threshold);               // [RULE5]
  // an unused scheme code behaves as the combined one, the most cautious stop
  assign opened =
    (scheme == bf_pkg::CURRENT_SCHEME)  ? cur_low :                        // [RULE5]
    (scheme == bf_pkg::POSITION_SCHEME) ? sif.pos_open :                   // [RULE6]
    (cur_low || sif.pos_open);                                             // [RULE7]
  assign no_pickup = cur_low && sif.pos_open;                              // [RULE19]

  assign sif.src_sel  = src_sel;
  assign sif.sup_time = supervision_time;
  assign sif.run      = (state == bf_pkg::ST_RUNNING);
  assign start        = (state == bf_pkg::ST_STANDBY) && sif.trig && !no_pickup;  // [RULE1]
  assign sif.start    = start;
  assign enter_trip   = (state == bf_pkg::ST_RUNNING) && !opened && sif.expired;  // [RULE3]

  // ---- supervision state machine
  always_comb begin
    next_state = state;
    unique case (state)
      bf_pkg::ST_STANDBY: begin
        if (start) begin
          next_state = bf_pkg::ST_RUNNING;                                 // [RULE1]
        end else if (sif.trig) begin
          next_state = bf_pkg::ST_REJECTED;                                // [RULE19]
        end
      end
      bf_pkg::ST_RUNNING: begin
        // the trigger only picks rejected or stand-by on an opening: a dropped trigger keeps timing
        if (opened) begin
          next_state = sif.trig ? bf_pkg::ST_REJECTED : bf_pkg::ST_STANDBY;  // [RULE4] [RULE8]
        end else if (sif.expired) begin
          next_state = bf_pkg::ST_TRIPPED;                                 // [RULE2] [RULE3]
        end
      end
      bf_pkg::ST_TRIPPED: begin
        if (!sif.trig) begin
          next_state = bf_pkg::ST_STANDBY;                                 // [RULE21]
        end
      end
      bf_pkg::ST_REJECTED: begin
        if (!sif.trig) begin
          next_state = bf_pkg::ST_STANDBY;                                 // [RULE9] [RULE10]
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state   <= bf_pkg::ST_STANDBY;
      trip    <= 1'b0;
      lockout <= 1'b0;
    end else begin
      state <= next_state;
      trip  <= (next_state == bf_pkg::ST_TRIPPED);                         // [RULE3] [RULE21]
      // set wins over an acknowledge in the same cycle
      if (enter_trip) begin
        lockout <= 1'b1;                                                   // [RULE11]
      end else if (ack_wr) begin
        lockout <= 1'b0;                                                   // [RULE12]
      end
    end
  end

  assign breaker_failure_o = trip;
  assign lockout_o         = lockout;

  // ---- checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_start_timer: assert property (  // [RULE1]
    (state == bf_pkg::ST_STANDBY && sif.trig && !no_pickup)
      |=> (state == bf_pkg::ST_RUNNING))
    else $error("trigger did not start supervision");

  a_run_on_drop: assert property (  // [RULE2]
    (sif.run && !sif.trig && !opened && !sif.expired) |=> sif.run)
    else $error("timer stopped by trigger drop");

  a_expire_trips: assert property (enter_trip |=> breaker_failure_o)  // [RULE3]
    else $error("expiry did not trip");

  a_trip_cause: assert property ($rose(breaker_failure_o) |-> $past(sif.expired))  // [RULE3]
    else $error("trip without timer expiry");

  a_open_no_trip: assert property (  // [RULE4]
    (sif.run && opened) |=> (!breaker_failure_o && !sif.run))
    else $error("opening did not stop timer");

  a_reject_no_trip: assert property (  // [RULE4]
    (state == bf_pkg::ST_REJECTED) |-> !breaker_failure_o)
    else $error("trip output high while rejected");

  // scheme checks watch the timer stop and the trip, not the opening decode
  a_cur_scheme: assert property (  // [RULE5]
    (scheme == bf_pkg::CURRENT_SCHEME && sif.run && cur_low) |=> !sif.run)
    else $error("current scheme opening wrong");

  a_cur_fail: assert property (  // [RULE5]
    (scheme == bf_pkg::CURRENT_SCHEME && sif.run && !cur_low && sif.expired)
      |=> breaker_failure_o)
    else $error("current scheme missed failure");

  a_pos_scheme: assert property (  // [RULE6]
    (scheme == bf_pkg::POSITION_SCHEME && sif.run && sif.pos_open) |=> !sif.run)
    else $error("position scheme opening wrong");

  a_pos_fail: assert property (  // [RULE6]
    (scheme == bf_pkg::POSITION_SCHEME && sif.run && !sif.pos_open && sif.expired)
      |=> breaker_failure_o)
    else $error("position scheme missed failure");

  a_comb_scheme: assert property (  // [RULE7]
    (scheme == bf_pkg::COMBINED_SCHEME && sif.run && !cur_low && !sif.pos_open && sif.expired)
      |=> breaker_failure_o)
    else $error("combined scheme missed failure");

  a_comb_stop: assert property (  // [RULE7]
    (scheme == bf_pkg::COMBINED_SCHEME && sif.run && (cur_low || sif.pos_open))
      |=> !breaker_failure_o)
    else $error("combined scheme tripped on an opening");

  a_reject_enter: assert property (  // [RULE8]
    (sif.run && opened && sif.trig) |=> (state == bf_pkg::ST_REJECTED))
    else $error("rejected state not entered");

  a_reject_hold: assert property (  // [RULE9]
    (state == bf_pkg::ST_REJECTED && sif.trig) |=> (state == bf_pkg::ST_REJECTED))
    else $error("left rejected while triggered");

  a_reject_no_run: assert property (  // [RULE9]
    (state == bf_pkg::ST_REJECTED && sif.trig) |=> (!sif.run && !sif.start))
    else $error("timer restarted while rejected");

  a_back_standby: assert property (  // [RULE10] [RULE21]
    (state inside {bf_pkg::ST_REJECTED, bf_pkg::ST_TRIPPED} && !sif.trig)
      |=> (state == bf_pkg::ST_STANDBY) ##1 !breaker_failure_o)
    else $error("no return to stand-by");

  a_lock_with_trip: assert property ($rose(breaker_failure_o) |-> lockout_o)  // [RULE11]
    else $error("lockout not set with trip");

  a_lock_latched: assert property ((lockout_o && !ack_wr) |=> lockout_o)  // [RULE12]
    else $error("lockout dropped without acknowledge");

  a_ack_clears: assert property ((ack_wr && !enter_trip) |=> !lockout_o)  // [RULE12]
    else $error("acknowledge did not clear lockout");

  a_trip_held: assert property (  // [RULE21]
    (state == bf_pkg::ST_TRIPPED && sif.trig) |=> breaker_failure_o)
    else $error("trip dropped while triggered");

  a_no_pickup: assert property (  // [RULE19]
    (state == bf_pkg::ST_STANDBY && no_pickup) |=> !sif.run)
    else $error("pickup with breaker open and low current");
endmodule // breaker_failure_top

// ### inc/bf_pkg.sv
// constants, field layout and state codes of the breaker-failure supervision block
package bf_pkg;
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned SUP_TIME_MS   = 100;
  localparam int unsigned SUP_TIME_CYC  = SUP_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned CUR_W         = 16;
  localparam int unsigned SYNC_N        = 4;

  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_TIME   = 8'h04;
  localparam logic [7:0] OFF_THRESH = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_ACK    = 8'h10;
  localparam logic [7:0] OFF_REMAIN = 8'h14;

  localparam int unsigned CTRL_SCHEME_LSB = 0;
  localparam int unsigned CTRL_SRC_LSB    = 2;
  localparam int unsigned ST_STATE_LSB    = 0;
  localparam int unsigned ST_TRIP_BIT     = 2;
  localparam int unsigned ST_LOCK_BIT     = 3;
  localparam int unsigned ST_TRIG_BIT     = 4;
  localparam int unsigned ST_OPEN_BIT     = 5;
  localparam int unsigned ACK_BIT         = 0;

  typedef enum logic [1:0] {
    CURRENT_SCHEME  = 2'h0,
    POSITION_SCHEME = 2'h1,
    COMBINED_SCHEME = 2'h2
  } scheme_t;

  typedef enum logic [1:0] {
    SRC_ANY_ASSIGNED      = 2'h0,
    SRC_EXTERNAL_ASSIGNED = 2'h1,
    SRC_OVERCURRENT       = 2'h2,
    SRC_NONE              = 2'h3
  } trig_src_t;

  typedef enum logic [1:0] {
    ST_STANDBY  = 2'h0,
    ST_RUNNING  = 2'h1,
    ST_TRIPPED  = 2'h3,
    ST_REJECTED = 2'h2
  } state_t;

  localparam logic [1:0]       RST_SCHEME = 2'h0;
  localparam logic [1:0]       RST_SRC    = 2'h0;
  localparam logic [CUR_W-1:0] RST_THRESH = 16'h0100;
endpackage

// ### inc/sup_if.sv
// carrier between the supervision controller, trigger selector and timer
`timescale 1ns/100ps
interface sup_if;
  logic        trig;
  logic        pos_open;
  logic [1:0]  src_sel;
  logic        start;
  logic        run;
  logic [31:0] sup_time;
  logic        expired;
  logic [31:0] remain;

  modport sel   (input src_sel, output trig, pos_open);
  modport timer (input start, run, sup_time, output expired, remain);
  modport ctrl  (input trig, pos_open, expired, remain,
                 output src_sel, start, run, sup_time);
endinterface

// ### src/bf_trigger_sel.sv
// trigger-source selection and pin synchronisers for extra triggers and position
`timescale 1ns/100ps
module bf_trigger_sel (
  input  wire logic core_clk_i,         // system clock
  input  wire logic sys_rst_i,          // sync reset, active high
  input  wire logic trip_ext_i,         // external trip assigned to breaker
  input  wire logic trip_oc_i,          // overcurrent trip assigned to breaker
  input  wire logic trip_other_i,       // any other assigned trip
  input  wire logic extra_trigger_a_i,  // extra trigger pin a
  input  wire logic extra_trigger_b_i,  // extra trigger pin b
  input  wire logic extra_trigger_c_i,  // extra trigger pin c
  input  wire logic pos_open_i,         // breaker open indicator pin
  sup_if.sel        sif                 // to the controller
);
  logic [bf_pkg::SYNC_N-1:0] pin_in;
  logic [bf_pkg::SYNC_N-1:0] filt;
  logic                      any_assigned_trip;
  logic                      external_assigned_trip;
  logic                      overcurrent_assigned_trip;
  logic                      chosen;
  logic                      extra_any;

  assign pin_in = {pos_open_i, extra_trigger_c_i, extra_trigger_b_i, extra_trigger_a_i};

  // the filt stage after s3 only settles a value once s2 and s3 agree, so a single
  // metastable sample never reaches the state machine
  for (genvar g = 0; g < bf_pkg::SYNC_N; g++) begin : g_sync
    logic s1, s2, s3;
    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        s1      <= 1'b0;
        s2      <= 1'b0;
        s3      <= 1'b0;
        filt[g] <= 1'b0;
      end else begin
        s1 <= pin_in[g];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          filt[g] <= s3;
        end
      end
    end
  end

  assign any_assigned_trip         = trip_ext_i | trip_oc_i | trip_other_i;  // [RULE14]
  assign external_assigned_trip    = trip_ext_i;                             // [RULE15]
  assign overcurrent_assigned_trip = trip_oc_i;                              // [RULE16]
  assign chosen = (sif.src_sel == bf_pkg::SRC_ANY_ASSIGNED)      ? any_assigned_trip :
                  (sif.src_sel == bf_pkg::SRC_EXTERNAL_ASSIGNED) ? external_assigned_trip :
                  (sif.src_sel == bf_pkg::SRC_OVERCURRENT)       ? overcurrent_assigned_trip :
                  1'b0;                                                      // [RULE17]
  assign extra_any = |filt[2:0];
  assign sif.trig     = chosen | extra_any;                                  // [RULE13] [RULE20]
  assign sif.pos_open = filt[3];

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_extra_starts: assert property (extra_any |-> sif.trig)  // [RULE13]
    else $error("extra trigger did not reach trigger");
  a_none_source: assert property (  // [RULE17]
    (sif.src_sel == bf_pkg::SRC_NONE && !extra_any) |-> !sif.trig)
    else $error("trip command triggered with no source selected");
  a_ext_only: assert property (  // [RULE15]
    (sif.src_sel == bf_pkg::SRC_EXTERNAL_ASSIGNED && !extra_any)
      |-> (sif.trig == trip_ext_i))
    else $error("external source selection wrong");
  a_oc_only: assert property (  // [RULE16]
    (sif.src_sel == bf_pkg::SRC_OVERCURRENT && !extra_any)
      |-> (sif.trig == trip_oc_i))
    else $error("overcurrent source selection wrong");
endmodule // bf_trigger_sel

// ### src/bf_sup_timer.sv
// down-counting supervision timer
`timescale 1ns/100ps
module bf_sup_timer (
  input  wire logic core_clk_i,  // system clock
  input  wire logic sys_rst_i,   // sync reset, active high
  sup_if.timer      sif          // from the controller
);
  logic [31:0] remain;
  logic [31:0] load_val;

  // a zero time still gives one cycle of supervision
  assign load_val    = (sif.sup_time == 32'h0) ? 32'h1 : sif.sup_time;
  assign sif.remain  = remain;
  assign sif.expired = sif.run && (remain <= 32'h1);  // [RULE3]

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      remain <= 32'h0;
    end else if (sif.start) begin
      remain <= load_val;  // [RULE1]
    end else if (sif.run && remain != 32'h0) begin
      remain <= remain - 32'h1;
    end
  end

  a_timer_load: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)  // [RULE1]
    sif.start |=> (remain == $past(load_val)))
    else $error("timer not loaded with supervision time");
endmodule // bf_sup_timer

// ### dv/breaker_model.sv
// behavioural circuit breaker with its current reading and open indicator
`timescale 1ns/100ps
module breaker_model #(
  parameter int OPEN_DLY = 5
) (
  input  wire logic                     core_clk_i,  // system clock
  input  wire logic                     open_i,      // trip coil energised
  input  wire logic                     cur_fault_i, // current reading stuck high
  input  wire logic                     pos_fault_i, // indicator stuck at closed
  output logic [bf_pkg::CUR_W-1:0]      current_o,   // measured current
  output logic                          pos_open_o   // indicator, high = open
);
  logic [OPEN_DLY-1:0] dly = '0;

  // contacts part a few cycles after the coil, far inside the supervision time
  always @(posedge core_clk_i) begin
    dly <= {dly[OPEN_DLY-2:0], open_i};
  end

  // a faulty reading keeps showing load current or a closed breaker
  assign current_o  = (dly[OPEN_DLY-1] && !cur_fault_i) ? 16'h0000 : 16'h0800;
  assign pos_open_o = dly[OPEN_DLY-1] && !pos_fault_i;
endmodule // breaker_model

// ### dv/breaker_failure_supervision_tb_top.sv
// self-checking bench for the breaker-failure supervision block
`timescale 1ns/100ps
module breaker_failure_supervision_tb_top;
  localparam logic [31:0] N = 32'h18;
  typedef struct packed {
    logic [1:0] src;
    logic [1:0] scheme;
    logic [2:0] trips;     // other, overcurrent, external
    logic [2:0] extras;    // c, b, a
    logic [1:0] faults;    // current, position
    logic       opens;
    logic [1:0] exp_state;
  } row_t;
  row_t rows [20] = '{
    '{2'h0, 2'h0, 3'h2, 3'h0, 2'h0, 1'b0, 2'h3},
    '{2'h0, 2'h0, 3'h1, 3'h0, 2'h0, 1'b0, 2'h3},
    '{2'h0, 2'h0, 3'h4, 3'h0, 2'h0, 1'b0, 2'h3},
    '{2'h1, 2'h0, 3'h2, 3'h0, 2'h0, 1'b0, 2'h0},
    '{2'h1, 2'h0, 3'h1, 3'h0, 2'h0, 1'b0, 2'h3},
    '{2'h2, 2'h0, 3'h1, 3'h0, 2'h0, 1'b0, 2'h0},
    '{2'h2, 2'h0, 3'h2, 3'h0, 2'h0, 1'b0, 2'h3},
    '{2'h2, 2'h0, 3'h4, 3'h0, 2'h0, 1'b0, 2'h0},
    '{2'h3, 2'h0, 3'h7, 3'h0, 2'h0, 1'b0, 2'h0},
    '{2'h3, 2'h0, 3'h0, 3'h1, 2'h0, 1'b0, 2'h3},
    '{2'h3, 2'h0, 3'h0, 3'h2, 2'h0, 1'b0, 2'h3},
    '{2'h1, 2'h0, 3'h0, 3'h4, 2'h0, 1'b0, 2'h3},
    '{2'h0, 2'h0, 3'h2, 3'h0, 2'h1, 1'b1, 2'h2},
    '{2'h0, 2'h0, 3'h2, 3'h0, 2'h2, 1'b1, 2'h3},
    '{2'h0, 2'h1, 3'h2, 3'h0, 2'h2, 1'b1, 2'h2},
    '{2'h0, 2'h1, 3'h2, 3'h0, 2'h1, 1'b1, 2'h3},
    '{2'h0, 2'h2, 3'h2, 3'h0, 2'h2, 1'b1, 2'h2},
    '{2'h0, 2'h3, 3'h2, 3'h0, 2'h2, 1'b1, 2'h2},
    '{2'h0, 2'h2, 3'h2, 3'h0, 2'h1, 1'b1, 2'h2},
    '{2'h0, 2'h2, 3'h2, 3'h0, 2'h3, 1'b1, 2'h3}
  };
  logic        core_clk_i = 1'b0;
  logic        sys_rst_i  = 1'b1;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic [2:0]  trips      = 3'h0;
  logic [2:0]  extras     = 3'h0;
  logic [1:0]  faults     = 2'h0;
  logic        brk_open   = 1'b0;
  logic        pready, pslverr, bf, lock, pos_open, err;
  logic [31:0] prdata, rd;
  logic [15:0] current;
  int          error_cnt   = 0;
  int          check_count = 0;
  row_t        r;

  breaker_failure_top #(.DEF_SUP_TIME_CYC(32'h14)) i_dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .trip_ext_i(trips[0]), .trip_oc_i(trips[1]),
    .trip_other_i(trips[2]), .extra_trigger_a_i(extras[0]),
    .extra_trigger_b_i(extras[1]), .extra_trigger_c_i(extras[2]),
    .pos_open_i(pos_open), .current_i(current), .breaker_failure_o(bf), .lockout_o(lock));

  breaker_model i_brk (
    .core_clk_i(core_clk_i), .open_i(brk_open), .cur_fault_i(faults[1]),
    .pos_fault_i(faults[0]), .current_o(current), .pos_open_o(pos_open));

  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end

  task end_sim();
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // always starts at a rising edge, so callers may come from a falling edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge core_clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    repeat (4) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    apb(1'b0, bf_pkg::OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, bf_pkg::OFF_TIME, 32'h0);
    chk(rd, 32'h14);
    apb(1'b0, bf_pkg::OFF_THRESH, 32'h0);
    chk(rd, 32'(bf_pkg::RST_THRESH));
    apb(1'b1, 8'h18, 32'hFFFFFFFF);
    chk(32'(err), 32'h1);
    apb(1'b1, bf_pkg::OFF_STATUS, 32'hFFFFFFFF);
    apb(1'b0, bf_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, bf_pkg::OFF_TIME, N);
    apb(1'b0, bf_pkg::OFF_TIME, 32'h0);
    chk(rd, N);
    foreach (rows[i]) begin
      r = rows[i];
      apb(1'b1, bf_pkg::OFF_CTRL, {28'h0, r.src, r.scheme});
      faults <= r.faults;
      brk_open <= 1'b0;
      repeat (12) @(posedge core_clk_i);
      trips <= r.trips;
      extras <= r.extras;
      brk_open <= r.opens;
      repeat (N + 12) @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk(32'(bf), 32'(r.exp_state == 2'h3));
      chk(32'(lock), 32'(r.exp_state == 2'h3));
      apb(1'b0, bf_pkg::OFF_STATUS, 32'h0);
      chk(32'(rd[1:0]), 32'(r.exp_state));
      trips <= 3'h0;
      extras <= 3'h0;
      repeat (10) @(posedge core_clk_i);
      apb(1'b0, bf_pkg::OFF_STATUS, 32'h0);
      chk(32'(rd[1:0]), 32'h0);
      chk(32'(bf), 32'h0);
      chk(32'(lock), 32'(r.exp_state == 2'h3));
      apb(1'b1, bf_pkg::OFF_ACK, 32'h1);
      @(negedge core_clk_i);
      chk(32'(lock), 32'h0);
    end
    // one-cycle trigger: timer must run on to exact expiry
    apb(1'b1, bf_pkg::OFF_CTRL, 32'h0);
    faults <= 2'h0;
    brk_open <= 1'b0;
    repeat (12) @(posedge core_clk_i);
    trips <= 3'h2;
    @(posedge core_clk_i);
    trips <= 3'h0;
    repeat (N - 1) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk(32'(bf), 32'h0);
    @(negedge core_clk_i);
    chk(32'(bf), 32'h1);
    chk(32'(lock), 32'h1);
    @(negedge core_clk_i);
    chk(32'(bf), 32'h0);
    apb(1'b1, bf_pkg::OFF_ACK, 32'h0);
    @(negedge core_clk_i);
    chk(32'(lock), 32'h1);
    apb(1'b1, bf_pkg::OFF_ACK, 32'h1);
    @(negedge core_clk_i);
    chk(32'(lock), 32'h0);
    // breaker already open with no current: trigger gives no pickup
    @(posedge core_clk_i);
    brk_open <= 1'b1;
    repeat (12) @(posedge core_clk_i);
    trips <= 3'h2;
    repeat (N + 12) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk(32'(bf), 32'h0);
    apb(1'b0, bf_pkg::OFF_STATUS, 32'h0);
    chk(32'(rd[5:0]), 32'h32);
    trips <= 3'h0;
    // reset in mid-run: a tripped, locked-out block comes back idle with defaults
    brk_open <= 1'b0;
    repeat (12) @(posedge core_clk_i);
    trips <= 3'h2;
    repeat (N + 4) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk(32'(lock), 32'h1);
    @(posedge core_clk_i);
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    trips <= 3'h0;
    @(negedge core_clk_i);
    chk(32'(bf), 32'h0);
    chk(32'(lock), 32'h0);
    apb(1'b0, bf_pkg::OFF_TIME, 32'h0);
    chk(rd, 32'h14);
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge core_clk_i);
    error_cnt++;
    end_sim();
  end
endmodule // breaker_failure_supervision_tb_top
